/* File: hw/ddr_cmd_consts.vh */
`ifndef DDR_CMD_CONSTS_VH
`define DDR_CMD_CONSTS_VH

// Command codes {ras_n, cas_n, we_n} with chip select low
`define DDR_CMD_NOP 3'b111
`define DDR_CMD_ACT 3'b011
`define DDR_CMD_RD 3'b101
`define DDR_CMD_WR 3'b100
`define DDR_CMD_BST 3'b110
`define DDR_CMD_PRE 3'b010
`define DDR_CMD_REF 3'b001
`define DDR_CMD_LMR 3'b000

// Bank address targets of a mode load
`define DDR_BA_BASE 2'b00
`define DDR_BA_EXT 2'b01

// Base mode register fields
`define DDR_MR_BL_MSB 2
`define DDR_MR_BL_LSB 0
`define DDR_MR_ORDER_BIT 3
`define DDR_MR_LAT_MSB 6
`define DDR_MR_LAT_LSB 4
`define DDR_MR_OP_MSB 12
`define DDR_MR_OP_LSB 7
`define DDR_MR_DLL_RST_BIT 8
`define DDR_OP_NORMAL 6'h00
`define DDR_OP_DLL_RST 6'h02

// Burst length codes
`define DDR_BL_2 3'h1
`define DDR_BL_4 3'h2
`define DDR_BL_8 3'h3

// Read latency codes and their half-clock counts
`define DDR_LAT_2 3'h2
`define DDR_LAT_2P5 3'h6
`define DDR_HALF_LAT_2 3'h4
`define DDR_HALF_LAT_2P5 3'h5
// Write data follows the command by one clock
`define DDR_HALF_LAT_WR 3'h2

// Extended register fields
`define DDR_EMR_DLL_OFF_BIT 0
`define DDR_EMR_DRIVE_BIT 1
`define DDR_EMR_FET_BIT 2

// Reset values of the configuration registers
`define DDR_MR_RESET 13'h0022
`define DDR_EMR_RESET 13'h0000

// Address fields of the command bus
`define DDR_AP_BIT 10
`define DDR_COL_MSB 9

// Bank tracker states
`define DDR_BK_IDLE 2'h0
`define DDR_BK_OPEN 2'h1
`define DDR_BK_CLOSING 2'h2

// Row close period in link clocks
`define DDR_ROW_CLOSE_CLKS 3

`endif

/* File: hw/ddr_bank_track.v */
`timescale 1ns/10ps
`default_nettype none
`include "ddr_cmd_consts.vh"

module ddr_bank_track #(
  parameter ROW_W = 13,
  parameter CLOSE_CLKS = `DDR_ROW_CLOSE_CLKS
) (
  input wire clk,
  input wire rst,
  input wire ck_tick,
  input wire activate,
  input wire precharge,
  input wire [ROW_W-1:0] row_in,
  output reg open_o,
  output reg [ROW_W-1:0] row_o
);

  reg [1:0] state_reg;
  reg [3:0] timer_reg;

  always @(posedge clk) begin
    if (rst) begin
      state_reg <= `DDR_BK_IDLE;
      timer_reg <= 4'h0;
      open_o <= 1'b0;
      row_o <= {ROW_W{1'b0}};
    end else begin
      case (state_reg)
        `DDR_BK_IDLE: begin
          // Precharge of an idle bank falls through as no operation
          if (activate) begin
            state_reg <= `DDR_BK_OPEN;
            row_o <= row_in;
            open_o <= 1'b1;
          end
        end
        `DDR_BK_OPEN: begin
          if (precharge) begin
            state_reg <= `DDR_BK_CLOSING;
            timer_reg <= CLOSE_CLKS[3:0];
            open_o <= 1'b0;
          end
        end
        `DDR_BK_CLOSING: begin
          // Repeated precharge here is ignored
          if (ck_tick) begin
            if (timer_reg <= 4'h1) begin
              state_reg <= `DDR_BK_IDLE;
            end else begin
              timer_reg <= timer_reg - 4'h1;
            end
          end
        end
        default: begin
          state_reg <= `DDR_BK_IDLE;
          open_o <= 1'b0;
        end
      endcase
    end
  end

endmodule
`default_nettype wire

/* File: hw/ddr_cmd_mode.v */
// Operation
// - Burst length two, four, eight; both orders
// - Burst wraps inside aligned length-sized block
// - Mode bit three picks burst order
// - Read data after latency two or 2.5
// - Operating bits zero select normal mode
// - Only bit eight set starts DLL reset
// - Bank code one writes extended register
// - Deselect ignores commands, work continues
// - NOP leaves operations in progress alone
// - ACTIVE opens row in chosen bank
// - READ bursts from column, A10 auto-closes
// - WRITE bursts to column, A10 auto-closes
// - Mask high drops byte, low stores it
// - PRECHARGE closes one or all banks
// - Precharge of idle or closing bank ignored
// - Sequential counts up, interleave xors count
// - Bank code zero writes base register
// - Base register field layout
// - Strobe decode of command set
`timescale 1ns/10ps
`default_nettype none
`include "ddr_cmd_consts.vh"

module ddr_cmd_mode #(
  parameter ROW_W = 13,
  parameter DATA_W = 16,
  parameter CLOSE_CLKS = `DDR_ROW_CLOSE_CLKS
) (
  input wire CLK_SYS,
  input wire RESET,
  input wire CK,
  input wire CKE,
  input wire CS_N,
  input wire RAS_N,
  input wire CAS_N,
  input wire WE_N,
  input wire [1:0] BA,
  input wire [12:0] ADDR,
  input wire [DATA_W/8-1:0] DM,
  input wire [DATA_W-1:0] DQ_IN,
  input wire [DATA_W-1:0] RD_DATA,
  output reg [DATA_W-1:0] DQ_OUT,
  output reg DQ_OE_N,
  output reg ARR_RD,
  output reg ARR_WR,
  output reg [DATA_W/8-1:0] ARR_BYTE_EN,
  output reg [DATA_W-1:0] ARR_WDATA,
  output reg [1:0] ARR_BANK,
  output reg [ROW_W-1:0] ARR_ROW,
  output reg [`DDR_COL_MSB:0] ARR_COL,
  output reg [3:0] BANK_OPEN,
  output reg [12:0] OPER_CFG,
  output reg [12:0] EXT_CFG,
  output reg DLL_RESET,
  output reg DLL_ON
);

  localparam NB = DATA_W / 8;
  localparam IN_W = 1 + 1 + 3 + 2 + 13 + NB + DATA_W;
  localparam ST_IDLE = 2'h0;
  localparam ST_WAIT = 2'h1;
  localparam ST_RUN = 2'h2;

  // Two flops on every DDR bus input (not RD_DATA); CK rides in the same chain to keep alignment
  reg [IN_W:0] sync1_reg;
  reg [IN_W:0] sync2_reg;
  reg ck_d_reg;

  always @(posedge CLK_SYS) begin
    if (RESET) begin
      sync1_reg <= {(IN_W+1){1'b1}};
      sync2_reg <= {(IN_W+1){1'b1}};
      ck_d_reg <= 1'b1;
    end else begin
      sync1_reg <= {CK, CKE, CS_N, RAS_N, CAS_N, WE_N, BA, ADDR, DM, DQ_IN};
      sync2_reg <= sync1_reg;
      ck_d_reg <= sync2_reg[IN_W];
    end
  end

  wire ck_s = sync2_reg[IN_W];
  wire cke_s = sync2_reg[IN_W-1];
  wire cs_n_s = sync2_reg[IN_W-2];
  wire [2:0] cmd_s = sync2_reg[IN_W-3:IN_W-5];
  wire [1:0] ba_s = sync2_reg[IN_W-6:IN_W-7];
  wire [12:0] a_s = sync2_reg[IN_W-8:IN_W-20];
  wire [NB-1:0] dm_s = sync2_reg[NB+DATA_W-1:DATA_W];
  wire [DATA_W-1:0] dq_s = sync2_reg[DATA_W-1:0];
  // Rises take commands; both edges step a burst
  wire ck_rise = ck_s & ~ck_d_reg;
  wire ck_edge = ck_s ^ ck_d_reg;

  // Deselect and NOP decode to nothing; running bursts carry on
  wire cmd_valid = ck_rise & cke_s & ~cs_n_s;
  wire is_act = cmd_valid & (cmd_s == `DDR_CMD_ACT);
  wire is_rd = cmd_valid & (cmd_s == `DDR_CMD_RD);
  wire is_wr = cmd_valid & (cmd_s == `DDR_CMD_WR);
  wire is_pre = cmd_valid & (cmd_s == `DDR_CMD_PRE);
  wire is_lmr = cmd_valid & (cmd_s == `DDR_CMD_LMR);

  // Configuration registers
  wire [5:0] op_code = a_s[`DDR_MR_OP_MSB:`DDR_MR_OP_LSB];
  wire op_ok = (op_code == `DDR_OP_NORMAL) | (op_code == `DDR_OP_DLL_RST);
  wire [12:0] mr_clr_mask = 13'h0001 << `DDR_MR_DLL_RST_BIT;

  always @(posedge CLK_SYS) begin
    if (RESET) begin
      OPER_CFG <= `DDR_MR_RESET;
      EXT_CFG <= `DDR_EMR_RESET;
      DLL_RESET <= 1'b0;
      DLL_ON <= 1'b0;
    end else begin
      DLL_RESET <= 1'b0;
      DLL_ON <= ~EXT_CFG[`DDR_EMR_DLL_OFF_BIT];
      if (is_lmr && ba_s == `DDR_BA_BASE && op_ok) begin
        // Reset bit self-clears; the request leaves as a pulse
        OPER_CFG <= a_s & ~mr_clr_mask;
        DLL_RESET <= (op_code == `DDR_OP_DLL_RST);
      end
      // Loads to other bank codes leave both registers alone
      if (is_lmr && ba_s == `DDR_BA_EXT) begin
        EXT_CFG <= a_s;
      end
    end
  end

  // Field decode of the base register
  wire [2:0] bl_code = OPER_CFG[`DDR_MR_BL_MSB:`DDR_MR_BL_LSB];
  wire [2:0] lat_code = OPER_CFG[`DDR_MR_LAT_MSB:`DDR_MR_LAT_LSB];
  wire order_il = OPER_CFG[`DDR_MR_ORDER_BIT];
  reg [2:0] len_mask;
  reg [2:0] rd_half_lat;

  always @* begin
    case (bl_code)
      `DDR_BL_2: len_mask = 3'h1;
      `DDR_BL_4: len_mask = 3'h3;
      `DDR_BL_8: len_mask = 3'h7;
      default: len_mask = 3'h1;
    endcase
    // Reserved latency codes fall back to 2.5, the slower safe choice
    case (lat_code)
      `DDR_LAT_2: rd_half_lat = `DDR_HALF_LAT_2;
      `DDR_LAT_2P5: rd_half_lat = `DDR_HALF_LAT_2P5;
      default: rd_half_lat = `DDR_HALF_LAT_2P5;
    endcase
  end

  // Burst engine
  reg [1:0] state_reg;
  reg [2:0] wait_reg;
  reg [2:0] beat_reg;
  reg [2:0] mask_reg;
  reg il_reg;
  reg is_wr_reg;
  reg ap_reg;
  reg [1:0] bank_reg;
  reg [`DDR_COL_MSB:0] col_reg;
  reg auto_pre;
  reg rd_pend_reg;

  wire [3:0] bank_open_w;
  wire [4*ROW_W-1:0] bank_row_w;
  wire tgt_open = bank_open_w[ba_s];
  wire start_burst = (is_rd | is_wr) & tgt_open;
  wire [2:0] seq_off = (col_reg[2:0] + beat_reg) & mask_reg;
  wire [2:0] il_off = (col_reg[2:0] ^ beat_reg) & mask_reg;
  wire [2:0] offs = il_reg ? il_off : seq_off;
  wire [2:0] base = col_reg[2:0] & ~mask_reg;
  wire [`DDR_COL_MSB:0] beat_col = {col_reg[`DDR_COL_MSB:3], base | offs};
  wire last_beat = (beat_reg == mask_reg);
  wire beat_go = (state_reg == ST_RUN) & ck_edge;

  always @(posedge CLK_SYS) begin
    if (RESET) begin
      state_reg <= ST_IDLE;
      wait_reg <= 3'h0;
      beat_reg <= 3'h0;
      mask_reg <= 3'h1;
      il_reg <= 1'b0;
      is_wr_reg <= 1'b0;
      ap_reg <= 1'b0;
      bank_reg <= 2'h0;
      col_reg <= {(`DDR_COL_MSB+1){1'b0}};
      auto_pre <= 1'b0;
    end else begin
      auto_pre <= 1'b0;
      if (start_burst) begin
        // A new burst command cuts off the one in flight
        state_reg <= ST_WAIT;
        // Entering the run state costs one edge of its own
        if (is_wr) begin
          wait_reg <= `DDR_HALF_LAT_WR - 3'h2;
        end else begin
          wait_reg <= rd_half_lat - 3'h2;
        end
        beat_reg <= 3'h0;
        mask_reg <= len_mask;
        il_reg <= order_il;
        is_wr_reg <= is_wr;
        ap_reg <= a_s[`DDR_AP_BIT];
        bank_reg <= ba_s;
        col_reg <= a_s[`DDR_COL_MSB:0];
      end else begin
        case (state_reg)
          ST_IDLE: state_reg <= ST_IDLE;
          ST_WAIT: begin
            if (ck_edge) begin
              if (wait_reg == 3'h0) begin
                state_reg <= ST_RUN;
              end else begin
                wait_reg <= wait_reg - 3'h1;
              end
            end
          end
          ST_RUN: begin
            if (ck_edge) begin
              beat_reg <= beat_reg + 3'h1;
              if (last_beat) begin
                state_reg <= ST_IDLE;
                auto_pre <= ap_reg;
              end
            end
          end
          default: state_reg <= ST_IDLE;
        endcase
      end
    end
  end

  // Per-bank row state
  genvar gi;
  generate
    for (gi = 0; gi < 4; gi = gi + 1) begin : g_bank
      // Auto-precharge closes only the bank its burst used
      wire pre_hit = (is_pre & (a_s[`DDR_AP_BIT] | (ba_s == gi))) |
                     (auto_pre & (bank_reg == gi));
      ddr_bank_track #(
        .ROW_W(ROW_W),
        .CLOSE_CLKS(CLOSE_CLKS)
      ) u_bank (
        .clk(CLK_SYS),
        .rst(RESET),
        .ck_tick(ck_rise),
        .activate(is_act & (ba_s == gi)),
        .precharge(pre_hit),
        .row_in(a_s[ROW_W-1:0]),
        .open_o(bank_open_w[gi]),
        .row_o(bank_row_w[gi*ROW_W +: ROW_W])
      );
    end
  endgenerate

  // Array side; masked bytes never reach the array
  always @(posedge CLK_SYS) begin
    if (RESET) begin
      ARR_RD <= 1'b0;
      ARR_WR <= 1'b0;
      ARR_BYTE_EN <= {NB{1'b0}};
      ARR_WDATA <= {DATA_W{1'b0}};
      ARR_BANK <= 2'h0;
      ARR_ROW <= {ROW_W{1'b0}};
      ARR_COL <= {(`DDR_COL_MSB+1){1'b0}};
      BANK_OPEN <= 4'h0;
      rd_pend_reg <= 1'b0;
      DQ_OUT <= {DATA_W{1'b0}};
      DQ_OE_N <= 1'b1;
    end else begin
      BANK_OPEN <= bank_open_w;
      ARR_RD <= beat_go & ~is_wr_reg;
      // No array write when every byte is masked
      ARR_WR <= beat_go & is_wr_reg & (dm_s != {NB{1'b1}});
      ARR_BYTE_EN <= ~dm_s;
      ARR_WDATA <= dq_s;
      if (beat_go) begin
        ARR_BANK <= bank_reg;
        ARR_ROW <= bank_row_w[bank_reg*ROW_W +: ROW_W];
        ARR_COL <= beat_col;
      end
      // Array answers one cycle after the strobe
      rd_pend_reg <= ARR_RD;
      if (rd_pend_reg) begin
        DQ_OUT <= RD_DATA;
      end
      if (rd_pend_reg) begin
        DQ_OE_N <= 1'b0;
      end else if (state_reg != ST_RUN && !ARR_RD) begin
        DQ_OE_N <= 1'b1;
      end
    end
  end

endmodule
`default_nettype wire

/* File: test/ddr_cmd_props_properties.sv */
`timescale 1ns/10ps
`default_nettype none
module ddr_cmd_props (
  input wire logic CLK_SYS,
  input wire logic RESET,
  input wire logic ARR_RD,
  input wire logic ARR_WR,
  input wire logic [1:0] ARR_BYTE_EN,
  input wire logic [1:0] ARR_BANK,
  input wire logic [3:0] BANK_OPEN,
  input wire logic DQ_OE_N,
  input wire logic [12:0] OPER_CFG,
  input wire logic [12:0] EXT_CFG,
  input wire logic DLL_RESET,
  input wire logic DLL_ON
);
  default clocking cb @(posedge CLK_SYS); endclocking
  default disable iff (RESET);
  property p_bit8; OPER_CFG[8] == 1'b0; endproperty
  a_bit8: assert property (p_bit8) else $error("bit8 kept");
  property p_dll_pulse; DLL_RESET |=> !DLL_RESET; endproperty
  a_dll_pulse: assert property (p_dll_pulse) else $error("dll pulse");
  property p_dll_on; !$past(RESET) |-> DLL_ON == !$past(EXT_CFG[0]); endproperty
  a_dll_on: assert property (p_dll_on) else $error("dll on");
  property p_wr_en; ARR_WR |-> ARR_BYTE_EN != 2'h0; endproperty
  a_wr_en: assert property (p_wr_en) else $error("empty write");
  property p_excl; !(ARR_RD && ARR_WR); endproperty
  a_excl: assert property (p_excl) else $error("rd and wr");
  property p_rd_open; ARR_RD |-> BANK_OPEN[ARR_BANK]; endproperty
  a_rd_open: assert property (p_rd_open) else $error("closed bank");
  property p_rd_oe; ARR_RD |-> ##2 !DQ_OE_N; endproperty
  a_rd_oe: assert property (p_rd_oe) else $error("no drive");
  property p_oe_cause; $fell(DQ_OE_N) |-> $past(ARR_RD, 2); endproperty
  a_oe_cause: assert property (p_oe_cause) else $error("stray drive");
endmodule
`default_nettype wire

/* File: test/ddr_ctl_model.sv */
`timescale 1ns/10ps
`default_nettype none
module ddr_ctl_model (
  input wire logic CLK_SYS,
  output logic CK,
  output logic CKE,
  output logic CS_N,
  output logic RAS_N,
  output logic CAS_N,
  output logic WE_N,
  output logic [1:0] BA,
  output logic [12:0] ADDR,
  output logic [1:0] DM,
  output logic [15:0] DQ_IN
);
  initial begin
    CK = 1'b0;
    CKE = 1'b1;
    CS_N = 1'b1;
    {RAS_N, CAS_N, WE_N} = 3'h7;
    BA = 2'h0;
    ADDR = 13'h0000;
    DM = 2'h0;
    DQ_IN = 16'h0000;
    #37;
    forever #80 CK = ~CK;
  end
  // Early-low change, far from CK rise; NOP between commands
  // Reserved op codes only when a test asks for them
  task automatic cmd(input logic cs_n, input logic [2:0] c,
    input logic [1:0] ba, input logic [12:0] a);
    @(negedge CK);
    @(negedge CLK_SYS);
    CS_N = cs_n;
    {RAS_N, CAS_N, WE_N} = c;
    BA = ba;
    ADDR = a;
    @(negedge CK);
    @(negedge CLK_SYS);
    {RAS_N, CAS_N, WE_N} = 3'h7;
    // Released lines change, so no stale value passes
    BA = ~ba;
    ADDR = ~a;
  endtask
endmodule
`default_nettype wire

/* File: test/ddr_sdram_command_mode_logic_tb.sv */
`timescale 1ns/10ps
`default_nettype none
`include "ddr_cmd_consts.vh"
module ddr_sdram_command_mode_logic_tb;
  logic CLK_SYS, RESET, CK, CKE, CS_N, RAS_N, CAS_N, WE_N;
  logic [1:0] BA, DM, ARR_BYTE_EN, ARR_BANK;
  logic [12:0] ADDR, ARR_ROW, OPER_CFG, EXT_CFG;
  logic [15:0] DQ_IN, DQ_OUT, ARR_WDATA;
  logic [15:0] RD_DATA = 16'h0000;
  logic [9:0] ARR_COL, c1, c2;
  logic [3:0] BANK_OPEN;
  logic DQ_OE_N, ARR_RD, ARR_WR, DLL_RESET, DLL_ON;
  logic p1 = 1'b0;
  logic p2 = 1'b0;
  int bad_count = 0;
  int n_checks = 0;
  int dll_cnt = 0;
  int ck_n = 0;
  int first_ck = 0;
  logic [9:0] beats[$];
  logic [17:0] wq[$];
  ddr_ctl_model i_ctl (.CLK_SYS(CLK_SYS), .CK(CK), .CKE(CKE), .CS_N(CS_N),
    .RAS_N(RAS_N), .CAS_N(CAS_N), .WE_N(WE_N), .BA(BA), .ADDR(ADDR),
    .DM(DM), .DQ_IN(DQ_IN));
  ddr_cmd_mode #(.CLOSE_CLKS(1)) i_dut (.CLK_SYS(CLK_SYS), .RESET(RESET),
    .CK(CK), .CKE(CKE), .CS_N(CS_N), .RAS_N(RAS_N), .CAS_N(CAS_N),
    .WE_N(WE_N), .BA(BA), .ADDR(ADDR), .DM(DM), .DQ_IN(DQ_IN),
    .RD_DATA(RD_DATA), .DQ_OUT(DQ_OUT), .DQ_OE_N(DQ_OE_N), .ARR_RD(ARR_RD),
    .ARR_WR(ARR_WR), .ARR_BYTE_EN(ARR_BYTE_EN), .ARR_WDATA(ARR_WDATA),
    .ARR_BANK(ARR_BANK), .ARR_ROW(ARR_ROW), .ARR_COL(ARR_COL),
    .BANK_OPEN(BANK_OPEN), .OPER_CFG(OPER_CFG), .EXT_CFG(EXT_CFG),
    .DLL_RESET(DLL_RESET), .DLL_ON(DLL_ON));
  initial begin
    CLK_SYS = 1'b0;
    forever #5 CLK_SYS = ~CLK_SYS;
  end
  always @(CK) ck_n++;
  always @(posedge CLK_SYS) begin
    if ((ARR_RD === 1'b1 || ARR_WR === 1'b1) && beats.size() == 0)
      first_ck <= ck_n;
    if (ARR_RD === 1'b1 || ARR_WR === 1'b1) beats.push_back(ARR_COL);
    if (ARR_WR === 1'b1) wq.push_back({ARR_BYTE_EN, ARR_WDATA});
    if (DLL_RESET === 1'b1) dll_cnt++;
  end
  // Array model tags data with its column, one cycle after the strobe
  always @(negedge CLK_SYS) begin
    RD_DATA <= {6'h2a, ARR_COL};
    p1 <= ARR_RD;
    c1 <= ARR_COL;
    p2 <= p1;
    c2 <= c1;
    if (p2 === 1'b1) check(DQ_OUT, {6'h2a, c2}, "read data");
  end
  task automatic check(input logic [17:0] got, input logic [17:0] exp,
    input string msg);
    n_checks++;
    if (got !== exp) begin
      bad_count++;
      $display("MISMATCH %0t %s got %h exp %h", $time, msg, got, exp);
    end
  endtask
  task automatic complete_run;
    if (bad_count == 0 && n_checks > 0)
      $display("TEST PASSED");
    else
      $display("TEST FAILED");
    $finish;
  endtask
  task automatic op(input logic [2:0] c, input logic [1:0] ba,
    input logic [12:0] a);
    i_ctl.cmd(1'b0, c, ba, a);
  endtask
  function automatic logic [9:0] exp_col(input logic [9:0] col, input int k,
    input int len, input logic il);
    logic [2:0] m;
    logic [2:0] off;
    m = 3'(len - 1);
    off = il ? 3'((col[2:0] ^ k) & m) : 3'((col[2:0] + k) & m);
    return {col[9:3], (col[2:0] & ~m) | off};
  endfunction
  task automatic t_mode;
    int d;
    check({OPER_CFG, DQ_OE_N, BANK_OPEN}, 18'h00450, "reset");
    check(EXT_CFG, 13'h0000, "ext reset");
    d = dll_cnt;
    op(`DDR_CMD_LMR, `DDR_BA_BASE, 13'h0163);
    check(OPER_CFG, 13'h0063, "dll load");
    check(dll_cnt - d, 1, "dll pulse");
    op(`DDR_CMD_LMR, `DDR_BA_BASE, 13'h0032);
    check(OPER_CFG, 13'h0032, "normal load");
    op(`DDR_CMD_LMR, `DDR_BA_BASE, 13'h0181);
    check(OPER_CFG, 13'h0032, "reserved op");
    op(`DDR_CMD_LMR, `DDR_BA_EXT, 13'h0007);
    check({EXT_CFG, DLL_ON}, 14'h000e, "ext load");
    op(`DDR_CMD_LMR, `DDR_BA_EXT, 13'h0000);
    op(`DDR_CMD_LMR, `DDR_BA_BASE, 13'h0122);
    check(DLL_ON, 1'b1, "dll on");
    repeat (200) @(posedge CK);
  endtask
  task automatic t_burst(input logic [2:0] bl, input logic il,
    input logic wr, input logic [1:0] dm);
    int len;
    int k;
    int t0;
    int h;
    len = 1 << bl;
    op(`DDR_CMD_PRE, 2'h0, 13'h0400);
    // Both latencies legal here; normal mode follows
    op(`DDR_CMD_LMR, `DDR_BA_BASE,
      {6'h00, il ? `DDR_LAT_2P5 : `DDR_LAT_2, il, bl});
    op(`DDR_CMD_ACT, 2'h1, 13'h1555);
    beats.delete();
    wq.delete();
    i_ctl.DM = dm;
    i_ctl.DQ_IN = 16'h5aa5;
    op(wr ? `DDR_CMD_WR : `DDR_CMD_RD, 2'h1, 13'h0405);
    t0 = ck_n - 1;
    h = wr ? `DDR_HALF_LAT_WR : il ? `DDR_HALF_LAT_2P5 : `DDR_HALF_LAT_2;
    for (k = 0; k < 400 && dm != 2'h3 && beats.size() < len; k++)
      @(negedge CLK_SYS);
    if (k == 400) begin
      check(beats.size(), len, "burst timeout");
      complete_run();
    end
    if (dm != 2'h3) check(first_ck - t0, h, "latency");
    op(`DDR_CMD_NOP, 2'h0, 13'h0000);
    op(`DDR_CMD_NOP, 2'h0, 13'h0000);
    check(beats.size(), dm == 2'h3 ? 0 : len, "beat count");
    check(BANK_OPEN, 4'h0, "auto precharge");
    check({ARR_BANK, ARR_ROW}, {2'h1, 13'h1555}, "row");
    for (k = 0; k < len && k < beats.size(); k++) begin
      check(beats[k], exp_col(10'h005, k, len, il), "col");
      if (wr) check(wq[k], {~dm, 16'h5aa5}, "write beat");
    end
  endtask
  task automatic t_bank;
    op(`DDR_CMD_ACT, 2'h3, 13'h0abc);
    i_ctl.cmd(1'b1, `DDR_CMD_ACT, 2'h2, 13'h0001);
    check(BANK_OPEN, 4'h8, "deselect");
    op(`DDR_CMD_BST, 2'h3, 13'h0000);
    op(`DDR_CMD_PRE, 2'h1, 13'h0000);
    check(BANK_OPEN, 4'h8, "idle precharge");
    op(`DDR_CMD_PRE, 2'h0, 13'h0400);
    check(BANK_OPEN, 4'h0, "precharge all");
  endtask
  initial begin
    RESET = 1'b1;
    repeat (4) @(posedge CLK_SYS);
    @(negedge CLK_SYS);
    RESET = 1'b0;
    t_mode();
    for (int b = 1; b < 4; b++) begin
      t_burst(3'(b), 1'b0, 1'b0, 2'h0);
      t_burst(3'(b), 1'b1, 1'b0, 2'h0);
    end
    t_burst(`DDR_BL_4, 1'b1, 1'b1, 2'h1);
    t_burst(`DDR_BL_2, 1'b0, 1'b1, 2'h3);
    t_bank();
    complete_run();
  end
endmodule
bind ddr_cmd_mode ddr_cmd_props i_props (.CLK_SYS(CLK_SYS), .RESET(RESET),
  .ARR_RD(ARR_RD), .ARR_WR(ARR_WR), .ARR_BYTE_EN(ARR_BYTE_EN),
  .ARR_BANK(ARR_BANK), .BANK_OPEN(BANK_OPEN), .DQ_OE_N(DQ_OE_N),
  .OPER_CFG(OPER_CFG), .EXT_CFG(EXT_CFG), .DLL_RESET(DLL_RESET),
  .DLL_ON(DLL_ON));
`default_nettype wire
